// >>> include/ccs_pkg.sv
// Constants shared by the converter configuration and status register bank
// Functional notes
// - Report captured edge position versus device clock as 24-bit status at index 0x2C.
// - Edge position status is read-only; content undefined until first capture.
// - Hold 16-bit full-scale code for input A at 0x30, reset 0xA000.
// - Hold separate 16-bit full-scale code for input B at 0x32, reset 0xA000.
// - Codes below 0x2000 down to 0x0000 are still accepted and applied.
// - Reference bypass bit 0 at 0x38 selects low analog supply as reference.
// - Stamp control bit 0 at 0x3B enables the stamp input receiver.
// - Stamp control bit 1 puts the stamp input in low-voltage PECL mode.
// - Reference bypass and stamp control reset to 0x00.
// - Serializer pre-emphasis register at 0x48 resets to 0x00.
package ccs_pkg;

	localparam int APB_ADDR_W = 12;
	localparam int APB_DATA_W = 32;

	localparam int CAPTURE_W = 24;
	localparam int FS_W      = 16;
	localparam int CTRL_W    = 8;

	// Printed offsets are register indices; the byte address is four times the index
	localparam int IDX_EDGE_CAPTURE = 'h2c;
	localparam int IDX_FS_CHAN_A    = 'h30;
	localparam int IDX_FS_CHAN_B    = 'h32;
	localparam int IDX_REF_BYPASS   = 'h38;
	localparam int IDX_STAMP_CTRL   = 'h3b;
	localparam int IDX_PREEMPHASIS  = 'h48;

	localparam logic [APB_ADDR_W-1:0] ADDR_EDGE_CAPTURE = APB_ADDR_W'(IDX_EDGE_CAPTURE * 4);
	localparam logic [APB_ADDR_W-1:0] ADDR_FS_CHAN_A    = APB_ADDR_W'(IDX_FS_CHAN_A * 4);
	localparam logic [APB_ADDR_W-1:0] ADDR_FS_CHAN_B    = APB_ADDR_W'(IDX_FS_CHAN_B * 4);
	localparam logic [APB_ADDR_W-1:0] ADDR_REF_BYPASS   = APB_ADDR_W'(IDX_REF_BYPASS * 4);
	localparam logic [APB_ADDR_W-1:0] ADDR_STAMP_CTRL   = APB_ADDR_W'(IDX_STAMP_CTRL * 4);
	localparam logic [APB_ADDR_W-1:0] ADDR_PREEMPHASIS  = APB_ADDR_W'(IDX_PREEMPHASIS * 4);

	localparam logic [CAPTURE_W-1:0] RST_EDGE_CAPTURE = 24'h000000;
	localparam logic [FS_W-1:0]      RST_FS_CODE      = 16'ha000;
	localparam logic [CTRL_W-1:0]    RST_REF_BYPASS   = 8'h00;
	localparam logic [CTRL_W-1:0]    RST_STAMP_CTRL   = 8'h00;
	localparam logic [CTRL_W-1:0]    RST_PREEMPHASIS  = 8'h00;

	localparam int BIT_REF_BYPASS  = 0;
	localparam int BIT_STAMP_RECV  = 0;
	localparam int BIT_STAMP_PECL  = 1;

	// Recommended lower bound of the full-scale code; lower codes still apply
	localparam logic [FS_W-1:0] FS_CODE_REC_MIN = 16'h2000;

endpackage : ccs_pkg

// >>> testbench/tb.sv
// Self-checking bench for the converter configuration and status register bank
`timescale 1ns/1ps
`default_nettype none
module tb;

	logic                               pclk;
	logic                               presetn;
	logic                               clk_en;
	logic                               psel;
	logic                               penable;
	logic                               pwrite;
	logic [ccs_pkg::APB_ADDR_W-1:0]     paddr;
	logic [ccs_pkg::APB_DATA_W-1:0]     pwdata;
	logic [3:0]                         pstrb;
	logic [ccs_pkg::APB_DATA_W-1:0]     prdata;
	logic                               pready;
	logic                               pslverr;
	logic [ccs_pkg::CAPTURE_W-1:0]      edge_pos_word;
	logic                               edge_pos_toggle;
	logic [ccs_pkg::FS_W-1:0]           fs_a;
	logic [ccs_pkg::FS_W-1:0]           fs_b;
	logic                               byp_en;
	logic                               recv_en;
	logic                               pecl_en;
	logic [ccs_pkg::CTRL_W-1:0]         preemph;
	logic [31:0]                        rdat;
	logic                               err;
	logic [31:0]                        code;
	logic [15:0]                        fs_codes [4] = '{16'h0000, 16'h1fff, 16'h2000, 16'hffff};
	int                                 failures;
	int                                 compares;
	int                                 cycles;

	ccs_regs ccs_regs_inst (
		.pclk                        (pclk),
		.presetn                     (presetn),
		.clk_en                      (clk_en),
		.psel                        (psel),
		.penable                     (penable),
		.pwrite                      (pwrite),
		.paddr                       (paddr),
		.pwdata                      (pwdata),
		.pstrb                       (pstrb),
		.prdata                      (prdata),
		.pready                      (pready),
		.pslverr                     (pslverr),
		.edge_pos_word               (edge_pos_word),
		.edge_pos_toggle             (edge_pos_toggle),
		.fullscale_code_chan_a       (fs_a),
		.fullscale_code_chan_b       (fs_b),
		.reference_bypass_en         (byp_en),
		.stamp_input_receiver_enable (recv_en),
		.stamp_input_pecl_enable     (pecl_en),
		.serializer_preemphasis      (preemph)
	);

	initial pclk = 1'b0;
	always #2.5 pclk = ~pclk;

	task automatic close_out();
		if (failures == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : close_out

	// Whole run needs a few hundred cycles; the ceiling leaves ample margin
	always @(posedge pclk) begin
		cycles = cycles + 1;
		if (cycles == 5000) begin
			failures = failures + 1;
			$display("[ERR] %0t timeout", $time);
			close_out();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares = compares + 1;
		if (got !== exp) begin
			failures = failures + 1;
			$display("[ERR] %0t mismatch got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// Ready is read at the rising edge, before that edge's register updates land
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
		output logic [31:0] rv, output logic er);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		pstrb   <= s;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rv = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
		apb(1'b1, a, d, s, rdat, err);
		chk(32'(err), 32'h0);
		@(negedge pclk);
	endtask : wr

	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0, 4'h0, rdat, err);
		chk(rdat, e);
		chk(32'(err), 32'h0);
	endtask : rd

	initial begin
		failures        = 0;
		compares        = 0;
		cycles          = 0;
		presetn         = 1'b0;
		clk_en          = 1'b1;
		psel            = 1'b0;
		penable         = 1'b0;
		pwrite          = 1'b0;
		paddr           = 12'h000;
		pwdata          = 32'h0;
		pstrb           = 4'h0;
		edge_pos_word   = 24'h000000;
		edge_pos_toggle = 1'b0;
		repeat (5) @(posedge pclk);
		@(negedge pclk);
		chk(32'(fs_a), 32'h0000a000);
		chk(32'(fs_b), 32'h0000a000);
		chk({29'h0, byp_en, recv_en, pecl_en}, 32'h0);
		chk(32'(preemph), 32'h0);
		@(posedge pclk);
		presetn <= 1'b1;
		rd(ccs_pkg::ADDR_EDGE_CAPTURE, 32'h0);
		rd(ccs_pkg::ADDR_FS_CHAN_A, 32'h0000a000);
		rd(ccs_pkg::ADDR_FS_CHAN_B, 32'h0000a000);
		rd(ccs_pkg::ADDR_REF_BYPASS, 32'h0);
		rd(ccs_pkg::ADDR_STAMP_CTRL, 32'h0);
		rd(ccs_pkg::ADDR_PREEMPHASIS, 32'h0);
		// Boundary codes on both channels; the two lowest lie below the recommended floor
		foreach (fs_codes[i]) begin
			code = 32'hffff0000 | 32'(fs_codes[i]);
			wr(ccs_pkg::ADDR_FS_CHAN_A, code, 4'hf);
			wr(ccs_pkg::ADDR_FS_CHAN_B, ~code, 4'hf);
			chk(32'(fs_a), {16'h0, code[15:0]});
			chk(32'(fs_b), {16'h0, ~code[15:0]});
			rd(ccs_pkg::ADDR_FS_CHAN_A, {16'h0, code[15:0]});
			rd(ccs_pkg::ADDR_FS_CHAN_B, {16'h0, ~code[15:0]});
		end
		wr(ccs_pkg::ADDR_FS_CHAN_A, 32'h00001234, 4'hf);
		wr(ccs_pkg::ADDR_FS_CHAN_A, 32'hffffabcd, 4'h1);
		chk(32'(fs_a), 32'h000012cd);
		// Bypass bit, then reserved bits alone
		wr(ccs_pkg::ADDR_REF_BYPASS, 32'h00000001, 4'hf);
		chk(32'(byp_en), 32'h1);
		wr(ccs_pkg::ADDR_REF_BYPASS, 32'h000000fe, 4'hf);
		chk(32'(byp_en), 32'h0);
		rd(ccs_pkg::ADDR_REF_BYPASS, 32'h000000fe);
		for (int i = 0; i < 4; i++) begin
			wr(ccs_pkg::ADDR_STAMP_CTRL, 32'(i) | 32'h000000a8, 4'hf);
			chk(32'(recv_en), 32'(i & 1));
			chk(32'(pecl_en), 32'((i >> 1) & 1));
			rd(ccs_pkg::ADDR_STAMP_CTRL, 32'(i) | 32'h000000a8);
		end
		wr(ccs_pkg::ADDR_PREEMPHASIS, 32'h000000a5, 4'hf);
		chk(32'(preemph), 32'h000000a5);
		rd(ccs_pkg::ADDR_PREEMPHASIS, 32'h000000a5);
		// Capture of a new edge position; word held well past the synchroniser delay
		@(posedge pclk);
		edge_pos_word <= 24'h5a3c81;
		@(posedge pclk);
		edge_pos_toggle <= ~edge_pos_toggle;
		repeat (8) @(posedge pclk);
		rd(ccs_pkg::ADDR_EDGE_CAPTURE, 32'h005a3c81);
		@(posedge pclk);
		edge_pos_word <= 24'ha5c37e;
		@(posedge pclk);
		edge_pos_toggle <= ~edge_pos_toggle;
		repeat (8) @(posedge pclk);
		rd(ccs_pkg::ADDR_EDGE_CAPTURE, 32'h00a5c37e);
		// Software may not overwrite the capture
		apb(1'b1, ccs_pkg::ADDR_EDGE_CAPTURE, 32'h00111111, 4'hf, rdat, err);
		chk(32'(err), 32'h1);
		rd(ccs_pkg::ADDR_EDGE_CAPTURE, 32'h00a5c37e);
		apb(1'b0, 12'h004, 32'h0, 4'h0, rdat, err);
		chk(32'(err), 32'h1);
		chk(rdat, 32'h0);
		// A stalled clock enable only stretches the transfer
		fork
			rd(ccs_pkg::ADDR_FS_CHAN_B, 32'h00000000);
			begin
				@(posedge pclk);
				clk_en <= 1'b0;
				repeat (3) @(posedge pclk);
				clk_en <= 1'b1;
			end
		join
		close_out();
	end

endmodule : tb
`default_nettype wire

// >>> verilog/ccs_regs.sv
// APB register bank for converter configuration and edge capture status
`timescale 1ns/1ps
`default_nettype none
module ccs_regs (
	// Clock, reset, enable
	input  wire logic                            pclk,
	input  wire logic                            presetn,
	input  wire logic                            clk_en,
	// APB slave
	input  wire logic                            psel,
	input  wire logic                            penable,
	input  wire logic                            pwrite,
	input  wire logic [ccs_pkg::APB_ADDR_W-1:0]  paddr,
	input  wire logic [ccs_pkg::APB_DATA_W-1:0]  pwdata,
	input  wire logic [3:0]                      pstrb,
	output logic      [ccs_pkg::APB_DATA_W-1:0]  prdata,
	output logic                                 pready,
	output logic                                 pslverr,
	// Edge position detector (analog timing domain)
	input  wire logic [ccs_pkg::CAPTURE_W-1:0]   edge_pos_word,
	input  wire logic                            edge_pos_toggle,
	// Configuration to the analog and serializer blocks
	output logic      [ccs_pkg::FS_W-1:0]        fullscale_code_chan_a,
	output logic      [ccs_pkg::FS_W-1:0]        fullscale_code_chan_b,
	output logic                                 reference_bypass_en,
	output logic                                 stamp_input_receiver_enable,
	output logic                                 stamp_input_pecl_enable,
	output logic      [ccs_pkg::CTRL_W-1:0]      serializer_preemphasis
);

	logic [ccs_pkg::CAPTURE_W-1:0]  edge_capture_reg;
	logic [ccs_pkg::FS_W-1:0]       fs_code_a_reg;
	logic [ccs_pkg::FS_W-1:0]       fs_code_b_reg;
	logic [ccs_pkg::CTRL_W-1:0]     ref_bypass_reg;
	logic [ccs_pkg::CTRL_W-1:0]     stamp_ctrl_reg;
	logic [ccs_pkg::CTRL_W-1:0]     preemphasis_reg;
	logic [ccs_pkg::APB_DATA_W-1:0] prdata_reg;
	logic                           pready_reg;
	logic                           pslverr_reg;

	logic [ccs_pkg::CAPTURE_W-1:0]  word_sync;
	logic                           toggle_sync;
	logic                           toggle_seen_reg;
	logic                           capture_event;

	logic                           access_phase;
	logic                           wr_commit;
	logic [ccs_pkg::APB_DATA_W-1:0] rdata_next;
	logic                           err_next;

	logic [ccs_pkg::APB_DATA_W-1:0] fs_a_merge;
	logic [ccs_pkg::APB_DATA_W-1:0] fs_b_merge;
	logic [ccs_pkg::APB_DATA_W-1:0] bypass_merge;
	logic [ccs_pkg::APB_DATA_W-1:0] stamp_merge;
	logic [ccs_pkg::APB_DATA_W-1:0] preemph_merge;

	// Word address match; the two low address bits are ignored
	function automatic logic reg_hit(
		input logic [ccs_pkg::APB_ADDR_W-1:0] addr,
		input logic [ccs_pkg::APB_ADDR_W-1:0] base
	);
		return addr[ccs_pkg::APB_ADDR_W-1:2] == base[ccs_pkg::APB_ADDR_W-1:2];
	endfunction : reg_hit

	// Byte-lane merge of write data into the old register content
	function automatic logic [31:0] lane_merge(
		input logic [31:0] old_val,
		input logic [31:0] wdata,
		input logic [3:0]  strb
	);
		logic [31:0] res;
		res = old_val;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = wdata[i*8 +: 8];
			end
		end
		return res;
	endfunction : lane_merge

	// ------------------------------------------------------------------
	// Edge position capture
	// ------------------------------------------------------------------

	// Word and toggle arrive from the analog timing logic; the word is held
	// stable around each toggle so both settle through equal latency
	ccs_sync #(
		.WIDTH (ccs_pkg::CAPTURE_W)
	) u_word_sync (
		.pclk     (pclk),
		.presetn  (presetn),
		.clk_en   (clk_en),
		.async_in (edge_pos_word),
		.sync_out (word_sync)
	);

	ccs_sync #(
		.WIDTH (1)
	) u_toggle_sync (
		.pclk     (pclk),
		.presetn  (presetn),
		.clk_en   (clk_en),
		.async_in (edge_pos_toggle),
		.sync_out (toggle_sync)
	);

	assign capture_event = toggle_sync ^ toggle_seen_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			toggle_seen_reg <= 1'b0;
		end else if (clk_en) begin
			toggle_seen_reg <= toggle_sync;
		end
	end

	// Only the detector updates this word; bus writes never reach it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			edge_capture_reg <= ccs_pkg::RST_EDGE_CAPTURE;
		end else if (clk_en && capture_event) begin
			edge_capture_reg <= word_sync;
		end
	end

	// ------------------------------------------------------------------
	// APB handshake: one wait state, answer in the second access cycle
	// ------------------------------------------------------------------

	assign access_phase = psel && penable;
	assign wr_commit    = clk_en && access_phase && pready_reg && pwrite;

	always_comb begin
		rdata_next = '0;
		err_next   = 1'b0;
		if (reg_hit(paddr, ccs_pkg::ADDR_EDGE_CAPTURE)) begin
			rdata_next = 32'(edge_capture_reg);
			err_next   = pwrite;
		end else if (reg_hit(paddr, ccs_pkg::ADDR_FS_CHAN_A)) begin
			rdata_next = 32'(fs_code_a_reg);
		end else if (reg_hit(paddr, ccs_pkg::ADDR_FS_CHAN_B)) begin
			rdata_next = 32'(fs_code_b_reg);
		end else if (reg_hit(paddr, ccs_pkg::ADDR_REF_BYPASS)) begin
			rdata_next = 32'(ref_bypass_reg);
		end else if (reg_hit(paddr, ccs_pkg::ADDR_STAMP_CTRL)) begin
			rdata_next = 32'(stamp_ctrl_reg);
		end else if (reg_hit(paddr, ccs_pkg::ADDR_PREEMPHASIS)) begin
			rdata_next = 32'(preemphasis_reg);
		end else begin
			err_next   = 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_reg <= 1'b0;
		end else if (clk_en) begin
			pready_reg <= access_phase && !pready_reg;
		end
	end

	// Read data is loaded with pready and held until the next load; error is loaded with pready and cleared on the next enabled cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_reg  <= '0;
			pslverr_reg <= 1'b0;
		end else if (clk_en) begin
			if (access_phase && !pready_reg) begin
				prdata_reg  <= pwrite ? '0 : rdata_next;
				pslverr_reg <= err_next;
			end else begin
				pslverr_reg <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------------
	// Configuration registers
	// ------------------------------------------------------------------

	assign fs_a_merge    = lane_merge(32'(fs_code_a_reg), pwdata, pstrb);
	assign fs_b_merge    = lane_merge(32'(fs_code_b_reg), pwdata, pstrb);
	assign bypass_merge  = lane_merge(32'(ref_bypass_reg), pwdata, pstrb);
	assign stamp_merge   = lane_merge(32'(stamp_ctrl_reg), pwdata, pstrb);
	assign preemph_merge = lane_merge(32'(preemphasis_reg), pwdata, pstrb);

	// Every code is taken as written; no clamping to the recommended range
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fs_code_a_reg <= ccs_pkg::RST_FS_CODE;
		end else if (wr_commit && reg_hit(paddr, ccs_pkg::ADDR_FS_CHAN_A)) begin
			fs_code_a_reg <= fs_a_merge[ccs_pkg::FS_W-1:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fs_code_b_reg <= ccs_pkg::RST_FS_CODE;
		end else if (wr_commit && reg_hit(paddr, ccs_pkg::ADDR_FS_CHAN_B)) begin
			fs_code_b_reg <= fs_b_merge[ccs_pkg::FS_W-1:0];
		end
	end

	// Whole byte is stored so reserved bits read back what was written
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ref_bypass_reg <= ccs_pkg::RST_REF_BYPASS;
		end else if (wr_commit && reg_hit(paddr, ccs_pkg::ADDR_REF_BYPASS)) begin
			ref_bypass_reg <= bypass_merge[ccs_pkg::CTRL_W-1:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stamp_ctrl_reg <= ccs_pkg::RST_STAMP_CTRL;
		end else if (wr_commit && reg_hit(paddr, ccs_pkg::ADDR_STAMP_CTRL)) begin
			stamp_ctrl_reg <= stamp_merge[ccs_pkg::CTRL_W-1:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			preemphasis_reg <= ccs_pkg::RST_PREEMPHASIS;
		end else if (wr_commit && reg_hit(paddr, ccs_pkg::ADDR_PREEMPHASIS)) begin
			preemphasis_reg <= preemph_merge[ccs_pkg::CTRL_W-1:0];
		end
	end

	// ------------------------------------------------------------------
	// Outputs, each a flip-flop or a bit of one
	// ------------------------------------------------------------------

	assign prdata                      = prdata_reg;
	assign pready                      = pready_reg;
	assign pslverr                     = pslverr_reg;
	assign fullscale_code_chan_a       = fs_code_a_reg;
	assign fullscale_code_chan_b       = fs_code_b_reg;
	assign reference_bypass_en         = ref_bypass_reg[ccs_pkg::BIT_REF_BYPASS];
	assign stamp_input_receiver_enable = stamp_ctrl_reg[ccs_pkg::BIT_STAMP_RECV];
	assign stamp_input_pecl_enable     = stamp_ctrl_reg[ccs_pkg::BIT_STAMP_PECL];
	assign serializer_preemphasis      = preemphasis_reg;

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------

	logic first_cycle_reg;

	// Frozen with the rest of the bank so it marks the first enabled edge after reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			first_cycle_reg <= 1'b1;
		end else if (clk_en) begin
			first_cycle_reg <= 1'b0;
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_setup;
		psel && !penable && clk_en;
	endsequence

	sequence s_access_wait;
		psel && penable && !pready_reg && clk_en;
	endsequence

	sequence s_full_write(logic [ccs_pkg::APB_ADDR_W-1:0] base);
		wr_commit && reg_hit(paddr, base) && (pstrb == 4'hf);
	endsequence

	apb_wait_state_a: assert property (
		s_setup ##1 s_access_wait |=> pready_reg && !$past(pready_reg)
	) else $error("pready not raised in second access cycle");

	capture_readonly_a: assert property (
		!(clk_en && capture_event) |=> $stable(edge_capture_reg)
	) else $error("edge capture changed without a capture event");

	capture_load_a: assert property (
		clk_en && capture_event |=> edge_capture_reg == $past(word_sync)
	) else $error("edge capture did not take the synchronised word");

	fs_code_a_a: assert property (
		s_full_write(ccs_pkg::ADDR_FS_CHAN_A) |=> fullscale_code_chan_a == $past(pwdata[15:0])
	) else $error("channel A full-scale code not written");

	fs_code_b_a: assert property (
		s_full_write(ccs_pkg::ADDR_FS_CHAN_B) |=>
			fullscale_code_chan_b == $past(pwdata[15:0]) && $stable(fullscale_code_chan_a)
	) else $error("channel B full-scale code not written separately");

	fs_low_code_a: assert property (
		s_full_write(ccs_pkg::ADDR_FS_CHAN_A) ##0 (pwdata[15:0] < ccs_pkg::FS_CODE_REC_MIN)
			|=> fullscale_code_chan_a == $past(pwdata[15:0])
	) else $error("low full-scale code was not accepted");

	ref_bypass_a: assert property (
		s_full_write(ccs_pkg::ADDR_REF_BYPASS) |=> reference_bypass_en == $past(pwdata[0])
	) else $error("reference bypass does not follow bit 0");

	stamp_recv_a: assert property (
		s_full_write(ccs_pkg::ADDR_STAMP_CTRL) |=> stamp_input_receiver_enable == $past(pwdata[0])
	) else $error("stamp receiver enable does not follow bit 0");

	stamp_pecl_a: assert property (
		s_full_write(ccs_pkg::ADDR_STAMP_CTRL) |=> stamp_input_pecl_enable == $past(pwdata[1])
	) else $error("stamp PECL mode does not follow bit 1");

	ctrl_reset_a: assert property (
		first_cycle_reg |-> ref_bypass_reg == ccs_pkg::RST_REF_BYPASS && stamp_ctrl_reg == ccs_pkg::RST_STAMP_CTRL
	) else $error("control registers not zero after reset");

	preemph_reset_a: assert property (
		first_cycle_reg |-> serializer_preemphasis == ccs_pkg::RST_PREEMPHASIS
			&& fullscale_code_chan_b == ccs_pkg::RST_FS_CODE
	) else $error("pre-emphasis or channel B code wrong after reset");

	reserved_keep_a: assert property (
		s_full_write(ccs_pkg::ADDR_STAMP_CTRL) |=> stamp_ctrl_reg[7:2] == $past(pwdata[7:2])
	) else $error("reserved stamp control bits not stored");

endmodule : ccs_regs
`default_nettype wire

// >>> verilog/ccs_sync.sv
// Two-flop synchroniser for signals arriving from outside the pclk domain
`timescale 1ns/1ps
`default_nettype none
module ccs_sync #(
	parameter int WIDTH = 1
) (
	// Clock, reset, enable
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic             clk_en,
	// Data
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_reg;

	// The first stage feeds only the second stage
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_reg <= '0;
			sync_out <= '0;
		end else if (clk_en) begin
			meta_reg <= async_in;
			sync_out <= meta_reg;
		end
	end

endmodule : ccs_sync
`default_nettype wire
